// ### rtl/dfr_pkg.sv
// Purpose: Shared constants and types of the DMA transfer engine
// Assumes: 32-bit register bus, 128-bit internal bus request data path
// Notes:   Sizes are coded 0 byte, 1 short, 2 word, 3 quad
package dfr_pkg;
   localparam int         CH_N        = 4;
   localparam int         DW          = 128;
   localparam logic [1:0] LEN_BYTE    = 2'h0;
   localparam logic [1:0] LEN_QUAD    = 2'h3;
   localparam logic [3:0] REG_SRC     = 4'h0;
   localparam logic [3:0] REG_DST     = 4'h4;
   localparam logic [3:0] REG_CNT     = 4'h8;
   localparam logic [3:0] REG_CFG     = 4'hC;
   localparam int         CFG_W       = 9;
   localparam int         CFG_GO      = 9;
   localparam int         CFG_BUSY    = 10;
   localparam int         CFG_ERR     = 11;
   localparam logic [25:0] MAP_HI     = 26'h0;
   // Internal data RAM occupies [0, IRAM_END); fly-by may not touch it
   localparam logic [31:0] IRAM_END   = 32'h0000_0400;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [4:0] SZ_ONE      = 5'h01;

   typedef struct packed {
      logic       dfix;
      logic       sfix;
      logic       dsync;
      logic       block;
      logic       flyby;
      logic [1:0] dlen;
      logic [1:0] slen;
   } dfr_cfg_t;

   typedef struct packed {
      logic          valid;
      logic          store;
      logic          flyby;
      logic [4:0]    size;
      logic [31:0]   addr;
      logic [DW-1:0] data;
   } dfr_breq_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_BUS  = 3'b010,
      ST_USER = 3'b100
   } dfr_state_t;
endpackage

// ### rtl/dfr_engine.sv
// Purpose: Four-channel DMA transfer engine with fly-by and packing
// Assumes: Bus controller splits each request to the region's width
// Notes:   Bus data is right-justified; byte lanes are the controller's job
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module dfr_engine
   import dfr_pkg::*;
(
   input  wire logic            ref_clk_i,
   input  wire logic            reset_i,
   input  wire logic [31:0]     s_axi_awaddr_i,
   input  wire logic            s_axi_awvalid_i,
   output logic                 s_axi_awready_o,
   input  wire logic [31:0]     s_axi_wdata_i,
   input  wire logic [3:0]      s_axi_wstrb_i,
   input  wire logic            s_axi_wvalid_i,
   output logic                 s_axi_wready_o,
   output logic [1:0]           s_axi_bresp_o,
   output logic                 s_axi_bvalid_o,
   input  wire logic            s_axi_bready_i,
   input  wire logic [31:0]     s_axi_araddr_i,
   input  wire logic            s_axi_arvalid_i,
   output logic                 s_axi_arready_o,
   output logic [31:0]          s_axi_rdata_o,
   output logic [1:0]           s_axi_rresp_o,
   output logic                 s_axi_rvalid_o,
   input  wire logic            s_axi_rready_i,
   input  wire logic [CH_N-1:0] dma_request_n_i,
   output logic [CH_N-1:0]      dma_acknowledge_n_o,
   output dfr_breq_t            breq_o,
   input  wire logic            breq_done_i,
   input  wire logic [DW-1:0]   breq_rdata_i,
   output logic                 data_oe_n_o,
   input  wire logic            user_pend_i,
   input  wire logic            user_done_i
);
   ////////////////////////////////////////////////////////////////////
   function automatic logic [4:0] step_sz(input logic [31:0] a,
      input logic [31:0] rem, input logic [1:0] ln, input logic fix);
      logic [4:0] s;
      s = SZ_ONE << ln;
      // Fixed ports must already be aligned, so never shrink them
      for (int k = 0; k < 4; k++) begin
         if (!fix && s > SZ_ONE && ((a[4:0] & (s - SZ_ONE)) != 5'h00
             || rem < 32'(s))) begin
            s = s >> 1;
         end
      end
      return s;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) r[8*b +: 8] = nw[8*b +: 8];
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   logic [31:0] aw_addr, next_aw_addr, w_data, next_w_data;
   logic [3:0]  w_strb, next_w_strb;
   logic        aw_got, next_aw_got, w_got, next_w_got;
   logic        wr_en;
   logic [31:0] src_a [CH_N], next_src [CH_N];
   logic [31:0] dst_a [CH_N], next_dst [CH_N];
   logic [31:0] cnt_a [CH_N], next_cnt [CH_N];
   dfr_cfg_t    cfg_a [CH_N], next_cfg [CH_N];
   logic [CH_N-1:0] busy, next_busy, err, next_err, tok, tok_clr;
   logic [31:0] rd_val, next_rdata;
   logic [1:0]  next_rresp, next_bresp;
   logic        next_awready, next_wready, next_bvalid;
   logic        next_arready, next_rvalid;

   always_comb begin
      next_aw_got  = aw_got;
      next_w_got   = w_got;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_axi_bvalid_o;
      next_bresp   = s_axi_bresp_o;
      next_rvalid  = s_axi_rvalid_o;
      next_rdata   = s_axi_rdata_o;
      next_rresp   = s_axi_rresp_o;
      wr_en        = aw_got && w_got && !s_axi_bvalid_o;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
         next_aw_got  = 1'b1;
         next_aw_addr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
         next_w_got  = 1'b1;
         next_w_data = s_axi_wdata_i;
         next_w_strb = s_axi_wstrb_i;
      end
      if (wr_en) begin
         next_aw_got = 1'b0;
         next_w_got  = 1'b0;
         next_bvalid = 1'b1;
         next_bresp  = (aw_addr[31:6] == MAP_HI) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
         next_bvalid = 1'b0;
      end
      case (s_axi_araddr_i[3:0])
         REG_SRC: rd_val = src_a[s_axi_araddr_i[5:4]];
         REG_DST: rd_val = dst_a[s_axi_araddr_i[5:4]];
         REG_CNT: rd_val = cnt_a[s_axi_araddr_i[5:4]];
         REG_CFG: begin
            rd_val = 32'(cfg_a[s_axi_araddr_i[5:4]]);
            rd_val[CFG_BUSY] = busy[s_axi_araddr_i[5:4]];
            rd_val[CFG_ERR]  = err[s_axi_araddr_i[5:4]];
         end
         default: rd_val = 32'h0000_0000;
      endcase
      if (s_axi_arvalid_i && s_axi_arready_o) begin
         next_rvalid = 1'b1;
         next_rdata  = (s_axi_araddr_i[31:6] == MAP_HI) ? rd_val : 32'h0000_0000;
         next_rresp  = (s_axi_araddr_i[31:6] == MAP_HI) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
         next_rvalid = 1'b0;
      end
      next_awready = !next_aw_got && !next_bvalid;
      next_wready  = !next_w_got && !next_bvalid;
      next_arready = !next_rvalid;
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 32'h0000_0000;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o <= 1'b0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= RESP_OKAY;
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h0000_0000;
         s_axi_rresp_o <= RESP_OKAY;
      end else begin
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         s_axi_awready_o <= next_awready;
         s_axi_wready_o <= next_wready;
         s_axi_bvalid_o <= next_bvalid;
         s_axi_bresp_o <= next_bresp;
         s_axi_arready_o <= next_arready;
         s_axi_rvalid_o <= next_rvalid;
         s_axi_rdata_o <= next_rdata;
         s_axi_rresp_o <= next_rresp;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Request pins: two-flop synchroniser, then a falling-edge token
   for (genvar g = 0; g < CH_N; g++) begin : g_req
      logic s1, s2, s3, next_tok;
      always_comb begin
         next_tok = tok[g] && !tok_clr[g];
         if (!s2 && s3 && !cfg_a[g].block) next_tok = 1'b1;
      end
      always_ff @(posedge ref_clk_i) begin
         if (reset_i) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
            tok[g] <= 1'b0;
         end else begin
            s1 <= dma_request_n_i[g];
            s2 <= s1;
            s3 <= s2;
            tok[g] <= next_tok;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   dfr_state_t state, next_state;
   dfr_breq_t  next_breq;
   logic [1:0] cur, next_cur, rr, next_rr, sel, wch;
   logic [DW-1:0] buf_q, next_buf;
   logic [4:0] fill, next_fill, dsz, sz;
   logic [CH_N-1:0] next_ack;
   logic       next_oe_n, found, need, ackon;
   dfr_cfg_t   c, wc;
   logic [31:0] cfgw;

   always_comb begin
      next_src = src_a;
      next_dst = dst_a;
      next_cnt = cnt_a;
      next_cfg = cfg_a;
      next_busy = busy;
      next_err = err;
      next_state = state;
      next_breq = breq_o;
      next_cur = cur;
      next_rr = rr;
      next_buf = buf_q;
      next_fill = fill;
      next_ack = dma_acknowledge_n_o;
      next_oe_n = data_oe_n_o;
      tok_clr = '0;
      wch = aw_addr[5:4];
      wc = cfg_a[wch];
      cfgw = merge(32'(wc), w_data, w_strb);
      // Running channels ignore writes so a transfer cannot be torn
      // Unmapped writes answer with an error and must leave every channel alone
      if (wr_en && !busy[wch] && aw_addr[31:6] == MAP_HI) begin
         case (aw_addr[3:0])
            REG_SRC: next_src[wch] = merge(src_a[wch], w_data, w_strb);
            REG_DST: next_dst[wch] = merge(dst_a[wch], w_data, w_strb);
            REG_CNT: next_cnt[wch] = merge(cnt_a[wch], w_data, w_strb);
            REG_CFG: begin
               wc = dfr_cfg_t'(cfgw[CFG_W-1:0]);
               next_cfg[wch] = wc;
               if (cfgw[CFG_GO]) begin
                  next_err[wch] = (wc.flyby && (wc.slen != wc.dlen
                     || src_a[wch] < IRAM_END || dst_a[wch] < IRAM_END))
                     || ((wc.slen == LEN_QUAD) != (wc.dlen == LEN_QUAD));
                  next_busy[wch] = !next_err[wch] && cnt_a[wch] != 32'h0;
               end
            end
            default: ;
         endcase
      end
      // Pick: a half-filled buffer locks the engine to its channel
      found = fill != 5'h00;
      sel = cur;
      for (int i = 0; i < CH_N; i++) begin
         if (!found && busy[2'(rr + i)]
             && (cfg_a[2'(rr + i)].block || tok[2'(rr + i)])) begin
            found = 1'b1;
            sel = 2'(rr + i);
         end
      end
      c = cfg_a[sel];
      dsz = step_sz(dst_a[sel], cnt_a[sel], c.dlen, c.dfix || c.flyby);
      if (c.flyby) begin
         sz = SZ_ONE << c.slen;
         need = !c.block;
      end else if (fill < dsz) begin
         sz = step_sz(src_a[sel], cnt_a[sel] - 32'(fill), c.slen, c.sfix);
         need = !c.block && !c.dsync;
      end else begin
         sz = dsz;
         need = !c.block && c.dsync;
      end
      ackon = need || c.flyby;
      case (state)
         ST_IDLE: begin
            if (found && (!need || tok[sel])) begin
               next_state = ST_BUS;
               next_cur = sel;
               tok_clr[sel] = need;
               next_breq.valid = 1'b1;
               next_breq.flyby = c.flyby;
               next_breq.size = sz;
               // Fly-by: store to dst when source-synced, else load src
               next_breq.store = c.flyby ? !c.dsync : !(fill < dsz);
               next_breq.addr = (next_breq.store) ? dst_a[sel] : src_a[sel];
               next_breq.data = buf_q;
               next_ack = ackon ? ~(CH_N'(1) << sel) : '1;
               next_oe_n = !(next_breq.store && !c.flyby);
            end
         end
         ST_BUS: begin
            if (breq_done_i) begin
               next_breq.valid = 1'b0;
               next_ack = '1;
               next_oe_n = 1'b1;
               next_rr = 2'(cur + 2'h1);
               c = cfg_a[cur];
               sz = breq_o.size;
               if (breq_o.flyby || !breq_o.store) begin
                  if (!c.sfix) next_src[cur] = src_a[cur] + 32'(sz);
               end
               if (breq_o.flyby || breq_o.store) begin
                  if (!c.dfix) next_dst[cur] = dst_a[cur] + 32'(sz);
                  next_cnt[cur] = cnt_a[cur] - 32'(sz);
                  next_busy[cur] = next_cnt[cur] != 32'h0;
               end
               if (!breq_o.flyby && !breq_o.store) begin
                  // Keep only the loaded bytes, append above the buffered ones
                  next_buf = buf_q | ((breq_rdata_i & ~({DW{1'b1}} << (8 * sz)))
                     << (8 * fill));
                  next_fill = fill + sz;
               end
               if (!breq_o.flyby && breq_o.store) begin
                  next_buf = buf_q >> (8 * sz);
                  next_fill = fill - sz;
               end
               next_state = user_pend_i ? ST_USER : ST_IDLE;
            end
         end
         ST_USER: begin
            if (user_done_i || !user_pend_i) next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         for (int i = 0; i < CH_N; i++) begin
            src_a[i] <= 32'h0000_0000;
            dst_a[i] <= 32'h0000_0000;
            cnt_a[i] <= 32'h0000_0000;
            cfg_a[i] <= '0;
         end
         busy <= '0;
         err <= '0;
         state <= ST_IDLE;
         breq_o <= '0;
         cur <= 2'h0;
         rr <= 2'h0;
         buf_q <= '0;
         fill <= 5'h00;
         dma_acknowledge_n_o <= '1;
         data_oe_n_o <= 1'b1;
      end else begin
         src_a <= next_src;
         dst_a <= next_dst;
         cnt_a <= next_cnt;
         cfg_a <= next_cfg;
         busy <= next_busy;
         err <= next_err;
         state <= next_state;
         breq_o <= next_breq;
         cur <= next_cur;
         rr <= next_rr;
         buf_q <= next_buf;
         fill <= next_fill;
         dma_acknowledge_n_o <= next_ack;
         data_oe_n_o <= next_oe_n;
      end
   end

   ////////////////////////////////////////////////////////////////////
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   a_ack_idle: assert property (!breq_o.valid |-> dma_acknowledge_n_o == '1)
      else $error("acknowledge outside a bus request");
   a_ack_single: assert property ($onehot0(~dma_acknowledge_n_o))
      else $error("more than one acknowledge");
   a_flyby_float: assert property (breq_o.valid && breq_o.flyby |-> data_oe_n_o)
      else $error("data driven during fly-by");
   a_flyby_iram: assert property (breq_o.valid && breq_o.flyby |-> breq_o.addr >= IRAM_END)
      else $error("fly-by touches internal RAM");
   a_block_notok: assert property (cfg_a[0].block && $stable(cfg_a[0]) |=> !tok[0])
      else $error("block channel took a request");
   a_ack_span: assert property (breq_o.valid && !breq_done_i |=> $stable(dma_acknowledge_n_o))
      else $error("acknowledge changed within a request");
   a_user_turn: assert property (breq_done_i && breq_o.valid && user_pend_i
      |=> !breq_o.valid [*2])
      else $error("no gap for user process");
   a_store_fill: assert property (breq_o.valid && breq_o.store && !breq_o.flyby
      |-> fill >= breq_o.size)
      else $error("store beyond buffered bytes");
   a_size_len: assert property (breq_o.valid && !breq_o.store
      |-> breq_o.size <= (SZ_ONE << cfg_a[cur].slen))
      else $error("load longer than request length");

   c_flyby: cover property (breq_o.valid && breq_o.flyby && breq_done_i);
   c_pack: cover property (breq_o.valid && breq_o.store && breq_o.size == 5'h04
      && cfg_a[cur].slen == LEN_BYTE);
   c_user: cover property (state == ST_USER);
endmodule

// ### verification/dfr_bus_model.sv
// Purpose: Bus controller and external device model
// Assumes: One request at a time, ended by a one-cycle done pulse
// Notes:   Load data follows the address, so packing order shows
`timescale 1ns/1ps
module dfr_bus_model
   import dfr_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic       reset_i,
   input  wire dfr_breq_t  breq_i,
   input  wire logic [3:0] wait_i,
   output logic            done_o,
   output logic [DW-1:0]   rdata_o
);
   logic [3:0]    cnt;
   logic [DW-1:0] pat;
   ////////////////////////////////////////
   // Region width hidden here: any size ends as one request
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || !breq_i.valid || done_o) begin
         done_o <= 1'b0;
         cnt    <= 4'h0;
      end else if (cnt >= wait_i) begin
         done_o <= 1'b1;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
   // Selected device drives or captures fly-by data on the bus itself
   assign pat     = {4{breq_i.addr + 32'h0000_0040}};
   // Idle bus shows the inverse, never a stale copy
   assign rdata_o = done_o ? pat : ~pat;
endmodule

// ### verification/dfr_engine_bench.sv
// Purpose: Self-checking bench of the DMA transfer engine
// Assumes: Channel registers at channel*0x10, designer's CFG layout
// Notes:   Every finished bus request is logged, then checked
`timescale 1ns/1ps
module dfr_engine_bench
   import dfr_pkg::*;
;
   logic            clk = 1'b0;
   logic            rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic            arvalid, arready, rvalid, rready, done, oe_n, upend, udone;
   logic [31:0]     awaddr, wdata, araddr, rdata;
   logic [1:0]      bresp, rresp;
   logic [3:0]      req_n, ack_n, lat;
   dfr_breq_t       breq;
   logic [DW-1:0]   brdata;
   int              failures, checked;
   logic [31:0]     q_a[$], q_k[$], q_d[$];

   dfr_engine i_dut (.ref_clk_i(clk), .reset_i(rst), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .dma_request_n_i(req_n), .dma_acknowledge_n_o(ack_n),
      .breq_o(breq), .breq_done_i(done), .breq_rdata_i(brdata), .data_oe_n_o(oe_n),
      .user_pend_i(upend), .user_done_i(udone));
   dfr_bus_model i_bus (.ref_clk_i(clk), .reset_i(rst), .breq_i(breq), .wait_i(lat),
      .done_o(done), .rdata_o(brdata));

   always #4 clk = ~clk;
   ////////////////////////////////////////
   function automatic logic [31:0] kind(input logic [3:0] a, input logic o, f, s,
                                        input logic [4:0] z);
      return {20'h0, a, o, f, s, z};
   endfunction
   // Log of finished requests: acknowledge, drivers, fly-by, store, size
   always @(posedge clk) begin
      if (breq.valid === 1'b1 && done === 1'b1) begin
         q_a.push_back(breq.addr);
         q_k.push_back(kind(ack_n, oe_n, breq.flyby, breq.store, breq.size));
         q_d.push_back(breq.data[31:0]);
      end
   end
   ////////////////////////////////////////
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic hang(input string what);
      failures++;
      $display("ERROR %s expected completion seen timeout", what);
      wrap_up();
   endtask
   task automatic chk(input string what, input logic [31:0] exp, got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_req(input int i, input logic [31:0] a, k);
      chk("request address", a, q_a[i]);
      chk("request kind", k, q_k[i]);
   endtask
   ////////////////////////////////////////
   task automatic axi_wr(input logic [31:0] a, d, output logic [1:0] r);
      int n;
      n = 0;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      while (n < 100) begin
         @(posedge clk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      r = bresp;
      if (bvalid !== 1'b1) hang("write response");
   endtask
   task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      int n;
      n = 0;
      araddr  <= a;
      arvalid <= 1'b1;
      while (n < 100) begin
         @(posedge clk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      d = rdata;
      r = rresp;
      if (rvalid !== 1'b1) hang("read data");
   endtask
   task automatic setup(input int ch, input logic [31:0] s, t, c, g);
      logic [1:0]  r;
      logic [31:0] b;
      b = 32'(ch) << 4;
      axi_wr(b + 32'(REG_SRC), s, r);
      axi_wr(b + 32'(REG_DST), t, r);
      axi_wr(b + 32'(REG_CNT), c, r);
      axi_wr(b + 32'(REG_CFG), g | 32'h0000_0200, r);
      chk("setup response", 32'(RESP_OKAY), 32'(r));
   endtask
   task automatic status(input int ch, output logic [31:0] d);
      logic [1:0] r;
      axi_rd((32'(ch) << 4) + 32'(REG_CFG), d, r);
   endtask
   task automatic wait_idle(input int ch);
      logic [31:0] d;
      for (int i = 0; i < 200; i++) begin
         status(ch, d);
         if (d[CFG_BUSY] === 1'b0) return;
      end
      hang("channel idle");
   endtask
   task automatic wait_log(input int n);
      for (int i = 0; i < 500; i++) begin
         if (q_a.size() >= n) return;
         @(posedge clk);
      end
      hang("bus request");
   endtask
   // Falling edge is one request; released before the next one
   task automatic pulse(input int ch);
      req_n[ch] <= 1'b0;
      repeat (4) @(posedge clk);
      req_n[ch] <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   ////////////////////////////////////////
   initial begin
      logic [31:0] d, cfgs [1:3];
      logic [1:0]  r;
      int          base, ld, sd;
      cfgs = '{32'h018, 32'h030, 32'h02B};
      // Response readies stay high, so back-to-back calls never toggle them
      rst = 1'b1; awvalid = 0; wvalid = 0; bready = 1; arvalid = 0; rready = 1;
      awaddr = 0; wdata = 0; araddr = 0; req_n = 4'hF; lat = 4'h5; upend = 0; udone = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("acknowledge idle", 32'hF, 32'(ack_n));
      chk("data drivers idle", 32'h1, 32'(oe_n));
      axi_wr(32'h40, 32'hFFFF_FFFF, r);
      chk("unmapped write response", 32'(RESP_SLVERR), 32'(r));
      axi_rd(32'h0, d, r);
      chk("unmapped write ignored", 32'h0, d);
      // Refused: unequal fly-by, fly-by in internal RAM, one side quad
      for (int i = 1; i < 4; i++) begin
         setup(i, (i == 2) ? 32'h100 : 32'h1000, 32'h2000, 32'h10, cfgs[i]);
         status(i, d);
         chk("error and busy", 32'h2, 32'(d[CFG_ERR:CFG_BUSY]));
      end
      chk("refused setups idle", 32'h0, 32'(q_a.size()));
      // Aliases channel 1 source, which now holds a non-zero address
      axi_rd(32'h50, d, r);
      chk("unmapped read response", 32'(RESP_SLVERR), 32'(r));
      chk("unmapped read data", 32'h0, d);
      // Block byte to word, slow bus, request pin pulsed meanwhile
      setup(0, 32'h1000, 32'h2000, 32'h4, 32'h028);
      pulse(0);
      wait_log(5);
      wait_idle(0);
      for (int i = 0; i < 4; i++) begin
         chk_req(i, 32'h1000 + 32'(i), kind(4'hF, 1'b1, 1'b0, 1'b0, 5'h01));
      end
      chk_req(4, 32'h2000, kind(4'hF, 1'b0, 1'b0, 1'b1, 5'h04));
      chk("packed word", 32'h4342_4140, q_d[4]);
      chk("block ignores pins", 32'h5, 32'(q_a.size()));
      // Source-synchronised word fly-by, prompt bus
      lat  <= 4'h0;
      base = q_a.size();
      setup(1, 32'h3000, 32'h4000, 32'h8, 32'h09A);
      repeat (20) @(posedge clk);
      chk("no request without pin", 32'(base), 32'(q_a.size()));
      for (int i = 0; i < 2; i++) begin
         pulse(1);
         wait_log(base + i + 1);
         chk_req(base + i, 32'h4000 + 32'(4 * i),
                 kind(4'hD, 1'b1, 1'b1, 1'b1, 5'h04));
      end
      wait_idle(1);
      chk("one request per unit", 32'(base + 2), 32'(q_a.size()));
      // Destination-synchronised byte fly-by
      base = q_a.size();
      setup(2, 32'h5000, 32'h6000, 32'h1, 32'h150);
      pulse(2);
      wait_log(base + 1);
      chk_req(base, 32'h5000, kind(4'hB, 1'b1, 1'b1, 1'b0, 5'h01));
      wait_idle(2);
      // Block fly-by: no pin, acknowledge plus address select both ends
      base = q_a.size();
      setup(2, 32'h5000, 32'h6000, 32'h1, 32'h030);
      wait_idle(2);
      chk_req(base, 32'h6000, kind(4'hB, 1'b1, 1'b1, 1'b1, 5'h01));
      // Byte to byte with the user program pending
      base = q_a.size();
      upend <= 1'b1;
      setup(3, 32'h7000, 32'h8000, 32'h1, 32'h020);
      wait_log(base + 1);
      repeat (6) @(posedge clk);
      chk("user turn holds engine", 32'h0, 32'(breq.valid));
      udone <= 1'b1;
      upend <= 1'b0;
      @(posedge clk);
      udone <= 1'b0;
      wait_log(base + 2);
      chk_req(base, 32'h7000, kind(4'hF, 1'b1, 1'b0, 1'b0, 5'h01));
      chk_req(base + 1, 32'h8000, kind(4'hF, 1'b0, 1'b0, 1'b1, 5'h01));
      chk("byte moved", 32'h40, q_d[base + 1] & 32'hFF);
      // Unaligned word to word: byte and short, aligned requests only
      base = q_a.size();
      setup(0, 32'h1001, 32'h2001, 32'h3, 32'h02A);
      wait_idle(0);
      chk_req(base, 32'h1001, kind(4'hF, 1'b1, 1'b0, 1'b0, 5'h01));
      ld = 0;
      sd = 0;
      for (int i = base; i < q_a.size(); i++) begin
         if (q_k[i][5]) sd += q_k[i][4:0];
         else ld += q_k[i][4:0];
         chk("request aligned", 32'h0, q_a[i] & (32'(q_k[i][4:0]) - 32'h1));
      end
      chk("bytes loaded", 32'h3, 32'(ld));
      chk("bytes stored", 32'h3, 32'(sd));
      wrap_up();
   end
   initial begin
      #800000;
      hang("whole run");
   end
endmodule
